/* File: core/mmac_pkg.sv */
// Purpose: Constants and carriers for the metering mode and accumulation
//          configuration bank.
// Assumes: Registers sit one per 32-bit word at byte address index*4.
// Notes:   Only the low byte of each word is meaningful.
package mmac_pkg;

    // Bus geometry
    localparam int unsigned ADDR_W = 18;
    localparam int unsigned DATA_W = 32;

    // Register indices and byte addresses
    localparam logic [15:0] IDX_MEAS_MODE = 16'hE700;
    localparam logic [15:0] IDX_ACC_MODE  = 16'hE701;
    localparam logic [15:0] IDX_STATUS    = 16'hE702;
    localparam logic [17:0] ADR_MEAS_MODE = {IDX_MEAS_MODE, 2'h0};
    localparam logic [17:0] ADR_ACC_MODE  = {IDX_ACC_MODE, 2'h0};
    localparam logic [17:0] ADR_STATUS    = {IDX_STATUS, 2'h0};

    // Field positions
    localparam int unsigned MM_PER_LSB  = 0;
    localparam int unsigned MM_PEAK_LSB = 2;
    localparam int unsigned AM_ACT_LSB  = 0;
    localparam int unsigned AM_VAR_LSB  = 2;

    // Reset values
    localparam logic [4:0] MM_RST = 5'h1C;
    localparam logic [7:0] AM_RST = 8'h00;

    // Period source codes
    localparam logic [1:0] PER_A   = 2'h0;
    localparam logic [1:0] PER_B   = 2'h1;
    localparam logic [1:0] PER_C   = 2'h2;
    localparam logic [1:0] PER_RSV = 2'h3;

    // Accumulation codes
    localparam logic [1:0] ACC_SIGNED = 2'h0;
    localparam logic [1:0] ACC_ABS    = 2'h3;
    localparam logic [1:0] VAR_STEER  = 2'h2;
    localparam logic [1:0] VAR_ABS    = 2'h3;

    // Avalon-MM request carrier
    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writedata;
        logic [3:0]        byteenable;
    } mmac_avs_req_type;

endpackage

/* File: core/mmac_config.sv */
// Purpose: Mode register bank steering period, peak and pulse-path
//          accumulation of a three-phase metering datapath.
// Assumes: One clock, synchronous reset, datapath samples flagged valid.
// Notes:   Access costs two cycles; pulse outputs saturate on negation.
`timescale 1ns/1ps

module mmac_config #(
    parameter int unsigned W              = 24, // Power sample width
    parameter bit          P_HAS_REACTIVE = 1'b1 // Reactive path fitted
) (
    input  wire logic                       i_clk,             // 40 MHz clock
    input  wire logic                       i_sys_rst,         // Sync reset, high
    input  wire logic                       i_ce,              // Clock enable
    input  wire mmac_pkg::mmac_avs_req_type i_avs,             // Bus request
    output logic                            o_avs_waitrequest, // Bus stall
    output logic [mmac_pkg::DATA_W-1:0]     o_avs_readdata,    // Read data
    input  wire logic                       i_smp_valid,       // Sample strobe
    input  wire logic [2:0]                 i_zx,              // Zero crossings
    input  wire logic [2:0][W-1:0]          i_act_pwr,         // Active powers
    input  wire logic [2:0][W-1:0]          i_var_pwr,         // Reactive powers
    output logic                            o_smp_valid,       // Output strobe
    output logic                            o_period_zx,       // Period crossing
    output logic                            o_peak_zx,         // Peak crossing
    output logic [1:0]                      o_period_source_sel, // Eff. phase
    output logic [2:0]                      o_peak_phase_sel,  // Peak enables
    output logic [2:0][W-1:0]               o_act_reg,         // Act to regs
    output logic [2:0][W-1:0]               o_act_cf,          // Act to pulses
    output logic [2:0][W-1:0]               o_var_reg,         // Var to regs
    output logic [2:0][W-1:0]               o_var_cf           // Var to pulses
);

    // Whole module state in one record
    typedef struct packed {
        logic [7:0]                  am;     // Accumulation mode
        logic [4:0]                  mm;     // Measurement mode, low bits
        logic                        ack;    // Access answered this cycle
        logic [mmac_pkg::DATA_W-1:0] rdata;  // Captured read data
        logic                        vld;    // Output sample strobe
        logic                        per_zx; // Selected period crossing
        logic                        pk_zx;  // Merged peak crossing
        logic [2:0][W-1:0]           act_reg; // Signed active
        logic [2:0][W-1:0]           act_cf;  // Pulse-path active
        logic [2:0][W-1:0]           var_reg; // Signed reactive
        logic [2:0][W-1:0]           var_cf;  // Pulse-path reactive
    } mmac_state_type;

    mmac_state_type st_ff;  // Registered state
    mmac_state_type nxt_st; // Next state

    logic              req;       // Any access pending
    logic              fire;      // Access completes at this edge
    logic [1:0]        per_eff;   // Effective period phase
    logic              act_abs;   // Active pulse path absolute
    logic [1:0]        var_code;  // Effective reactive code
    logic              var_steer; // Reactive sign follows active
    logic              var_abs;   // Reactive pulse path absolute
    logic [7:0]        rd_byte;   // Read mux result
    logic [7:0]        status;    // Effective mode summary
    logic [2:0][W-1:0] act_cf_w;  // Per-phase pulse active
    logic [2:0][W-1:0] var_cf_w;  // Per-phase pulse reactive

    // Negate, saturating the most negative code to keep the sign right
    function automatic logic [W-1:0] f_neg(input logic [W-1:0] x);
        logic [W-1:0] lo;
        lo = {1'b1, {(W-1){1'b0}}};
        if (x == lo)
        begin
            f_neg = ~lo;
        end
        else
        begin
            f_neg = ~x + {{(W-1){1'b0}}, 1'b1};
        end
    endfunction

    // Access handshake; stalls while frozen so no access is lost
    assign req               = i_avs.read | i_avs.write;
    assign fire              = req & st_ff.ack & i_ce;
    assign o_avs_waitrequest = req & ~(st_ff.ack & i_ce);
    assign o_avs_readdata    = st_ff.rdata;

    // Reserved period code folds onto phase A
    assign per_eff = (st_ff.mm[1:0] == mmac_pkg::PER_RSV) ?
                     mmac_pkg::PER_A : st_ff.mm[1:0];

    // Active: only code 11 changes anything, 01 and 10 stay signed
    assign act_abs = (st_ff.am[1:0] == mmac_pkg::ACC_ABS);

    // Reactive field forced to signed on variants without it
    assign var_code  = P_HAS_REACTIVE ? st_ff.am[3:2] : mmac_pkg::ACC_SIGNED;
    assign var_steer = (var_code == mmac_pkg::VAR_STEER);
    assign var_abs   = (var_code == mmac_pkg::VAR_ABS);

    // Read-only summary of what the datapath is really doing
    assign status = {3'h0, var_code, act_abs, per_eff};

    // Read mux; reserved measurement bits read as zero
    assign rd_byte = (i_avs.address == mmac_pkg::ADR_MEAS_MODE) ? {3'h0, st_ff.mm} :
                     (i_avs.address == mmac_pkg::ADR_ACC_MODE)  ? st_ff.am :
                     (i_avs.address == mmac_pkg::ADR_STATUS)    ? status :
                     8'h00;

    // Per-phase pulse-path shaping
    genvar p;
    for (p = 0; p < 3; p++)
    begin : g_ph
        logic act_neg; // Active sample below zero
        logic var_neg; // Reactive sample below zero
        logic var_inv; // Reactive needs inversion
        assign act_neg = i_act_pwr[p][W-1];
        assign var_neg = i_var_pwr[p][W-1];
        // Zero active power counts as positive
        assign var_inv = (var_steer & act_neg) | (var_abs & var_neg);
        assign act_cf_w[p] = (act_abs & act_neg) ? f_neg(i_act_pwr[p]) :
                             i_act_pwr[p];
        assign var_cf_w[p] = var_inv ? f_neg(i_var_pwr[p]) : i_var_pwr[p];
    end

    // Next state: bus access and sample processing
    always_comb
    begin
        nxt_st = st_ff;
        // Answer one cycle after the request appears
        nxt_st.ack = req & ~st_ff.ack;
        if (req & ~st_ff.ack)
        begin
            nxt_st.rdata = {24'h000000, rd_byte};
        end
        // Writes land on the answering edge, low lane only
        if (st_ff.ack & i_avs.write & i_avs.byteenable[0])
        begin
            if (i_avs.address == mmac_pkg::ADR_MEAS_MODE)
            begin
                nxt_st.mm = i_avs.writedata[4:0];
            end
            else if (i_avs.address == mmac_pkg::ADR_ACC_MODE)
            begin
                nxt_st.am = i_avs.writedata[7:0];
                if (!P_HAS_REACTIVE)
                begin
                    nxt_st.am[3:2] = mmac_pkg::ACC_SIGNED;
                end
            end
        end
        // Datapath uses the modes held before this edge
        nxt_st.vld = i_smp_valid;
        if (i_smp_valid)
        begin
            nxt_st.per_zx  = i_zx[per_eff];
            // Crossings on every enabled phase shorten the peak period
            nxt_st.pk_zx   = |(i_zx & st_ff.mm[4:2]);
            // Register path is always signed
            nxt_st.act_reg = i_act_pwr;
            nxt_st.var_reg = i_var_pwr;
            nxt_st.act_cf  = act_cf_w;
            nxt_st.var_cf  = var_cf_w;
        end
    end

    // State register; reset restores field defaults
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            st_ff    <= '0;
            st_ff.mm <= mmac_pkg::MM_RST;
            st_ff.am <= mmac_pkg::AM_RST;
        end
        else if (i_ce)
        begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from state
    assign o_smp_valid         = st_ff.vld;
    assign o_period_zx         = st_ff.per_zx;
    assign o_peak_zx           = st_ff.pk_zx;
    assign o_period_source_sel = per_eff;
    assign o_peak_phase_sel    = st_ff.mm[4:2];
    assign o_act_reg           = st_ff.act_reg;
    assign o_act_cf            = st_ff.act_cf;
    assign o_var_reg           = st_ff.var_reg;
    assign o_var_cf            = st_ff.var_cf;

    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    // A sample taken while running
    sequence s_smp;
        i_ce && i_smp_valid;
    endsequence

    // A fresh request seen, then a running cycle
    sequence s_req_seen;
        (req && !st_ff.ack && i_ce) ##1 i_ce;
    endsequence

    a_wait_answer: assert property (
        s_req_seen |-> !o_avs_waitrequest)
        else $error("access not answered in two cycles");

    a_reset_defaults: assert property (
        $past(i_sys_rst) |-> (o_peak_phase_sel == 3'h7) &&
                             (st_ff.am == 8'h00) &&
                             (o_period_source_sel == 2'h0))
        else $error("defaults wrong after reset");

    a_write_applies: assert property (
        (fire && i_avs.write && i_avs.byteenable[0] &&
         (i_avs.address == mmac_pkg::ADR_MEAS_MODE))
        |=> (o_peak_phase_sel == $past(i_avs.writedata[4:2])))
        else $error("written peak select not applied");

    a_period_sel_b: assert property (
        (s_smp and (st_ff.mm[1:0] == 2'h1)) |=> (o_period_zx == $past(i_zx[1])))
        else $error("period not taken from phase B");

    a_period_rsv_a: assert property (
        (s_smp and (st_ff.mm[1:0] == 2'h3)) |=> (o_period_zx == $past(i_zx[0])))
        else $error("reserved period code not phase A");

    a_peak_merge: assert property (
        s_smp |=> (o_peak_zx == |($past(i_zx) & $past(st_ff.mm[4:2]))))
        else $error("peak crossings not merged");

    a_meas_rsv_zero: assert property (
        (fire && i_avs.read && (i_avs.address == mmac_pkg::ADR_MEAS_MODE))
        |-> (o_avs_readdata[7:5] == 3'h0))
        else $error("reserved bits read nonzero");

    a_act_signed_cf: assert property (
        (s_smp and (st_ff.am[1:0] != 2'h3)) |=> (o_act_cf == $past(i_act_pwr)))
        else $error("active pulse path not signed");

    a_act_abs_cf: assert property (
        (s_smp and (st_ff.am[1:0] == 2'h3)) |=>
        (!o_act_cf[0][W-1] && (o_act_reg == $past(i_act_pwr))))
        else $error("active absolute mode wrong");

    a_var_steer_inv: assert property (
        (s_smp and (var_code == 2'h2) and i_act_pwr[1][W-1] and
         (i_var_pwr[1] == {{(W-1){1'b0}}, 1'b1}))
        |=> (o_var_cf[1] == {W{1'b1}}) && (o_var_reg[1] == $past(i_var_pwr[1])))
        else $error("reactive not inverted by active sign");

    a_var_signed_cf: assert property (
        (s_smp and (var_code[1] == 1'b0)) |=> (o_var_cf == $past(i_var_pwr)))
        else $error("reactive pulse path not signed");

    // Period crossing follows phase A for code 00
    a_period_sel_a: assert property (
        (s_smp and (st_ff.mm[1:0] == 2'h0)) |=> (o_period_zx == $past(i_zx[0])))
        else $error("period not taken from phase A");

    // Period crossing follows phase C for code 10
    a_period_sel_c: assert property (
        (s_smp and (st_ff.mm[1:0] == 2'h2)) |=> (o_period_zx == $past(i_zx[2])))
        else $error("period not taken from phase C");

    // The reserved code never reaches the datapath
    a_period_no_rsv: assert property (
        o_period_source_sel != 2'h3)
        else $error("reserved period code passed on");

    // A lone phase A enable ignores crossings elsewhere
    a_peak_single: assert property (
        (s_smp and (st_ff.mm[4:2] == 3'h1)) |=> (o_peak_zx == $past(i_zx[0])))
        else $error("peak crossing not from phase A alone");

    // Register path copy of active power is never altered
    a_act_reg_copy: assert property (
        s_smp |=> (o_act_reg == $past(i_act_pwr)))
        else $error("active register path altered");

    // Code 00 leaves the active pulse path signed
    a_act_zero_cf: assert property (
        (s_smp and (st_ff.am[1:0] == 2'h0)) |=> (o_act_cf == $past(i_act_pwr)))
        else $error("active code 00 not signed");

    // Register path copy of reactive power is never altered
    a_var_reg_copy: assert property (
        s_smp |=> (o_var_reg == $past(i_var_pwr)))
        else $error("reactive register path altered");

    // Variants without reactive keep the field at zero
    a_var_field_held: assert property (
        !P_HAS_REACTIVE |-> (st_ff.am[3:2] == 2'h0))
        else $error("reactive field not held at zero");

    // Non-negative active power passes reactive untouched when steering
    a_var_steer_pos: assert property (
        (s_smp and (var_code == 2'h2) and !i_act_pwr[0][W-1])
        |=> (o_var_cf[0] == $past(i_var_pwr[0])))
        else $error("reactive altered with positive active");

    // Every accepted sample yields one output strobe
    a_smp_strobe: assert property (
        s_smp |=> o_smp_valid)
        else $error("sample strobe missing");

    // Without a sample the strobe drops and data holds
    a_smp_hold: assert property (
        (i_ce && !i_smp_valid) |=> (!o_smp_valid && $stable(o_act_reg)))
        else $error("outputs moved without a sample");

    // Clock enable low freezes every bit of state
    a_ce_freeze: assert property (
        !i_ce |=> $stable(st_ff))
        else $error("state moved while frozen");

    // A frozen bank never answers, so no access is lost
    a_ce_stall: assert property (
        (req && !i_ce) |-> o_avs_waitrequest)
        else $error("access answered while frozen");

    // Only the low byte lane ever carries data
    a_rdata_upper: assert property (
        o_avs_readdata[31:8] == 24'h000000)
        else $error("upper read lanes not zero");

    // Reset clears the sample path as well as restoring the mode defaults
    a_reset_path: assert property (
        $past(i_sys_rst) |-> (!o_smp_valid && (o_act_cf == '0) && (o_var_cf == '0)))
        else $error("sample path not cleared by reset");

    // Writes that skip the low lane leave the modes alone
    a_lane_refused: assert property (
        (fire && i_avs.write && !i_avs.byteenable[0]) |=> $stable(st_ff.mm))
        else $error("write without low lane applied");

endmodule

/* File: test/test_metering_mode_accum_config.sv */
// Purpose: Self-checking bench for the mode and accumulation register bank.
// Assumes: Design defaults, W=24 with the reactive path fitted.
// Notes:   Bus answers are taken at the edge; outputs are read 1 ns later.
`timescale 1ns/1ps

module test_metering_mode_accum_config;
    localparam logic [17:0] ADR_MM  = mmac_pkg::ADR_MEAS_MODE; // Measurement mode
    localparam logic [17:0] ADR_AM  = mmac_pkg::ADR_ACC_MODE;  // Accumulation mode
    localparam logic [17:0] ADR_UNM = 18'h39C0C;              // Nothing mapped here
    // Phase A, B, C powers; C reactive is most negative to hit saturation
    localparam logic [2:0][23:0] ACT = {24'h000000, 24'hFFFF38, 24'h000064};
    localparam logic [2:0][23:0] VAR = {24'h800000, 24'h000001, 24'hFFFFF9};

    logic                       i_clk;        // Bench clock
    logic                       i_sys_rst;    // Sync reset
    logic                       i_ce;         // Clock enable, on except in t_freeze
    mmac_pkg::mmac_avs_req_type req;          // Bus request
    logic                       wait_req;     // Bus stall
    logic [31:0]                rdata;        // Bus read data
    logic                       smp_v;        // Sample strobe
    logic [2:0]                 zx;           // Zero crossings
    logic                       smp_o;        // Output strobe
    logic                       per_zx;       // Period crossing
    logic                       pk_zx;        // Peak crossing
    logic [1:0]                 per_sel;      // Effective period phase
    logic [2:0]                 pk_sel;       // Peak enables
    logic [2:0][23:0]           act_reg;      // Active to registers
    logic [2:0][23:0]           act_cf;       // Active to pulses
    logic [2:0][23:0]           var_reg;      // Reactive to registers
    logic [2:0][23:0]           var_cf;       // Reactive to pulses
    int                         error_cnt;    // Mismatches
    int                         checks_done;  // Comparisons
    int                         cycles;       // Hang guard

    mmac_config i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_avs(req),
        .o_avs_waitrequest(wait_req), .o_avs_readdata(rdata), .i_smp_valid(smp_v),
        .i_zx(zx), .i_act_pwr(ACT), .i_var_pwr(VAR), .o_smp_valid(smp_o),
        .o_period_zx(per_zx), .o_peak_zx(pk_zx), .o_period_source_sel(per_sel),
        .o_peak_phase_sel(pk_sel), .o_act_reg(act_reg), .o_act_cf(act_cf),
        .o_var_reg(var_reg), .o_var_cf(var_cf));

    // Free-running 40 MHz clock
    always #12.5 i_clk = ~i_clk;

    // Hang guard: far above the few hundred cycles the tests need
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            print_verdict();
        end
    end

    // Saturating negate, so the most negative value cannot wrap
    function automatic logic [23:0] negx(input logic [23:0] x);
        return (x == 24'h800000) ? 24'h7FFFFF : 24'h000000 - x;
    endfunction
    function automatic logic [23:0] absx(input logic [23:0] x);
        return x[23] ? negx(x) : x;
    endfunction
    // Pulse-path reactive value for one code; zero active counts positive
    function automatic logic [23:0] var_exp(input int code, input int p);
        if (code == 2)
            return ACT[p][23] ? negx(VAR[p]) : VAR[p];
        return (code == 3) ? absx(VAR[p]) : VAR[p];
    endfunction

    // Count and report one comparison
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // One bus access; held until waitrequest is seen low at an edge
    task automatic bus(input logic rd, input logic [17:0] adr, input logic [31:0] wd,
                       input logic [3:0] be, output logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        req <= '{read: rd, write: !rd, address: adr, writedata: wd, byteenable: be};
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (wait_req !== 1'b0 && n < 20);
        d = rdata;
        cmp("waitrequest", 32'h0, 32'(wait_req));
        req.read <= 1'b0;
        req.write <= 1'b0;
        #1;
    endtask
    task automatic wr(input logic [17:0] adr, input logic [31:0] wd);
        logic [31:0] d;
        bus(1'b0, adr, wd, 4'hF, d);
    endtask
    task automatic rd_chk(input logic [17:0] adr, input logic [31:0] exp, input string nm);
        logic [31:0] d;
        bus(1'b1, adr, 32'h0, 4'hF, d);
        cmp(nm, exp, d);
    endtask

    // One sample through the datapath, outputs read a cycle later
    task automatic smp(input logic [2:0] z);
        @(posedge i_clk);
        smp_v <= 1'b1;
        zx <= z;
        @(posedge i_clk);
        smp_v <= 1'b0;
        #1;
        cmp("smp_valid", 32'h1, 32'(smp_o));
    endtask

    task automatic do_reset();
        @(posedge i_clk);
        i_sys_rst <= 1'b1;
        repeat (20) @(posedge i_clk);
        i_sys_rst <= 1'b0;
    endtask

    // Reset values of both registers and the effective selections
    task automatic t_defaults();
        rd_chk(ADR_MM, 32'h1C, "measurement_mode");
        rd_chk(ADR_AM, 32'h00, "accumulation_mode");
        cmp("peak_phase_sel", 32'h7, 32'(pk_sel));
        cmp("period_source_sel", 32'h0, 32'(per_sel));
        $display("test defaults done");
    endtask

    // Every period code, reserved bits written high, one crossing per phase
    task automatic t_period();
        int s;
        for (int k = 0; k < 4; k++)
        begin
            s = (k == 3) ? 0 : k;
            wr(ADR_MM, 32'hE0 | 32'(k));
            rd_chk(ADR_MM, 32'(k), "measurement_mode");
            cmp("period_source_sel", 32'(s), 32'(per_sel));
            rd_chk(mmac_pkg::ADR_STATUS, 32'(s), "status");
            for (int p = 0; p < 3; p++)
            begin
                smp(3'(1 << p));
                cmp("period_zx", 32'(p == s), 32'(per_zx));
                cmp("peak_zx", 32'h0, 32'(pk_zx));
            end
        end
        $display("test period done");
    endtask

    // All peak enable mixes against every nonzero crossing mix
    task automatic t_peak();
        for (int m = 0; m < 8; m++)
        begin
            wr(ADR_MM, 32'(m << 2));
            cmp("peak_phase_sel", 32'(m), 32'(pk_sel));
            for (int z = 1; z < 8; z++)
            begin
                smp(3'(z));
                cmp("peak_zx", 32'((m & z) != 0), 32'(pk_zx));
            end
        end
        $display("test peak done");
    endtask

    // Every active and reactive code pair, sampled right after the write
    task automatic t_accum();
        for (int k = 0; k < 16; k++)
        begin
            wr(ADR_AM, 32'(k));
            smp(3'h0);
            for (int p = 0; p < 3; p++)
            begin
                cmp("act_reg", 32'(ACT[p]), 32'(act_reg[p]));
                cmp("act_cf", 32'((k % 4 == 3) ? absx(ACT[p]) : ACT[p]), 32'(act_cf[p]));
                cmp("var_reg", 32'(VAR[p]), 32'(var_reg[p]));
                cmp("var_cf", 32'(var_exp(k / 4, p)), 32'(var_cf[p]));
            end
        end
        $display("test accum done");
    endtask

    // Clock enable low swallows a sample; peak mask is all phases here
    task automatic t_freeze();
        @(posedge i_clk);
        i_ce <= 1'b0;
        smp_v <= 1'b1;
        zx <= 3'h7;
        @(posedge i_clk);
        @(posedge i_clk);
        i_ce <= 1'b1;
        smp_v <= 1'b0;
        #1;
        cmp("smp_valid", 32'h0, 32'(smp_o));
        cmp("peak_zx", 32'h0, 32'(pk_zx));
        $display("test freeze done");
    endtask

    // Refused writes, an unmapped place, then reset in mid-run
    task automatic t_refuse_reset();
        logic [31:0] d;
        wr(ADR_MM, 32'h01);
        bus(1'b0, ADR_MM, 32'h02, 4'hE, d);
        rd_chk(ADR_MM, 32'h01, "measurement_mode");
        wr(ADR_UNM, 32'hFF);
        rd_chk(ADR_UNM, 32'h0, "unmapped");
        wr(ADR_AM, 32'h0F);
        do_reset();
        t_defaults();
        $display("test refuse_reset done");
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        i_clk = 1'b0;
        i_sys_rst = 1'b1;
        i_ce = 1'b1;
        req = '0;
        smp_v = 1'b0;
        zx = 3'h0;
        error_cnt = 0;
        checks_done = 0;
        cycles = 0;
        do_reset();
        t_defaults();
        t_period();
        t_peak();
        t_accum();
        t_freeze();
        t_refuse_reset();
        print_verdict();
    end
endmodule
